/* File: inc/bkcv_defs.vh */
`ifndef BKCV_DEFS_VH
`define BKCV_DEFS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define BKCV_OFS_RAIL3_CONTROL 8'h08
`define BKCV_OFS_RAIL3_LIMITS_RAMP 8'h09
`define BKCV_OFS_RAIL0_TARGET_VOLTAGE 8'h0A
`define BKCV_OFS_RAIL0_FLOOR_VOLTAGE 8'h0B
`define BKCV_OFS_RAIL1_TARGET_VOLTAGE 8'h0C

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define BKCV_RST_RAIL3_CONTROL 8'hCA
`define BKCV_RST_RAIL3_LIMITS_RAMP 8'h2A
`define BKCV_RST_RAIL0_TARGET_VOLTAGE 8'h39
`define BKCV_RST_RAIL0_FLOOR_VOLTAGE 8'h00
`define BKCV_RST_RAIL1_TARGET_VOLTAGE 8'h75
`define BKCV_RD_UNMAPPED 8'h00

// ----------------------------------------------------------------
// rail3_control field positions
// ----------------------------------------------------------------
`define BKCV_BIT_CONVERTER3_ON 7
`define BKCV_BIT_PIN_GATING_ON_3 6
`define BKCV_BIT_GATE_PIN_CHOICE_3 5
`define BKCV_BIT_LEVEL_PIN_MODE_3 4
`define BKCV_BIT_DISCHARGE_ON_3 3
`define BKCV_BIT_FORCED_SWITCHING_3 1

// ----------------------------------------------------------------
// rail3_limits_ramp field positions
// ----------------------------------------------------------------
`define BKCV_ILIM_MSB 5
`define BKCV_ILIM_LSB 3
`define BKCV_RAMP_MSB 2
`define BKCV_RAMP_LSB 0

// ----------------------------------------------------------------
// current limit decode, in mA
// ----------------------------------------------------------------
`define BKCV_ILIM_CODE_MIN 3'h2
`define BKCV_ILIM_BASE_MA 13'h09C4
`define BKCV_ILIM_STEP_MA 13'h01F4

// ----------------------------------------------------------------
// voltage code decode, in uV
// ----------------------------------------------------------------
`define BKCV_VSEG1_TOP 8'h17
`define BKCV_VSEG2_BASE 8'h18
`define BKCV_VSEG2_TOP 8'h9D
`define BKCV_VSEG3_BASE 8'h9E
`define BKCV_VSEG1_UV 22'h07_A120
`define BKCV_VSEG1_STEP_UV 22'h00_2710
`define BKCV_VSEG2_UV 22'h0B_3718
`define BKCV_VSEG2_STEP_UV 22'h00_1388
`define BKCV_VSEG3_UV 22'h15_AAE0
`define BKCV_VSEG3_STEP_UV 22'h00_4E20

// ----------------------------------------------------------------
// ramp step per microsecond, in uV, by ramp code
// ----------------------------------------------------------------
`define BKCV_SLEW0_UV 22'h00_7530
`define BKCV_SLEW1_UV 22'h00_3A98
`define BKCV_SLEW2_UV 22'h00_2710
`define BKCV_SLEW3_UV 22'h00_1D4C
`define BKCV_SLEW4_UV 22'h00_0ED8
`define BKCV_SLEW5_UV 22'h00_076C
`define BKCV_SLEW6_UV 22'h00_03AC
`define BKCV_SLEW7_UV 22'h00_0190

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
// one ramp tick per microsecond: 40 cycles of 25 ns, counted 0..39
`define BKCV_RAMP_TICK_LAST 6'h27

`endif

/* File: verilog/bkcv_ramp.v */
`include "bkcv_defs.vh"

// decodes one voltage code and slews the rail output toward it
module bkcv_ramp (
  // clock and reset
  input wire clk,
  input wire srst,
  // controls
  input wire tick,
  input wire run,
  input wire [7:0] code,
  input wire [2:0] speed,
  // rail output voltage in uV
  output reg [21:0] vout_uv,
  output wire settled
);

  // ----------------------------------------------------------------
  // code decode
  // ----------------------------------------------------------------
  wire [21:0] code_w;
  reg [21:0] target_uv;
  reg [21:0] step_uv;
  wire [21:0] gap_up;
  wire [21:0] gap_dn;

  assign code_w = {14'h0000, code};

  always @* begin
    if (code <= `BKCV_VSEG1_TOP) begin
      target_uv = `BKCV_VSEG1_UV + code_w * `BKCV_VSEG1_STEP_UV;
    end else if (code <= `BKCV_VSEG2_TOP) begin
      target_uv = `BKCV_VSEG2_UV + (code_w - {14'h0000, `BKCV_VSEG2_BASE})
        * `BKCV_VSEG2_STEP_UV;
    end else begin
      target_uv = `BKCV_VSEG3_UV + (code_w - {14'h0000, `BKCV_VSEG3_BASE})
        * `BKCV_VSEG3_STEP_UV;
    end
  end

  always @* begin
    case (speed)
      3'h0: step_uv = `BKCV_SLEW0_UV;
      3'h1: step_uv = `BKCV_SLEW1_UV;
      3'h2: step_uv = `BKCV_SLEW2_UV;
      3'h3: step_uv = `BKCV_SLEW3_UV;
      3'h4: step_uv = `BKCV_SLEW4_UV;
      3'h5: step_uv = `BKCV_SLEW5_UV;
      3'h6: step_uv = `BKCV_SLEW6_UV;
      default: step_uv = `BKCV_SLEW7_UV;
    endcase
  end

  // ----------------------------------------------------------------
  // slew: one step per microsecond, same rate up and down
  // ----------------------------------------------------------------
  assign gap_up = target_uv - vout_uv;
  assign gap_dn = vout_uv - target_uv;
  assign settled = run && (vout_uv == target_uv);

  always @(posedge clk) begin
    if (srst || !run) begin
      vout_uv <= 22'h00_0000;
    end else if (tick) begin
      if (vout_uv < target_uv) begin
        vout_uv <= (gap_up > step_uv) ? vout_uv + step_uv
          : target_uv;
      end else if (vout_uv > target_uv) begin
        vout_uv <= (gap_dn > step_uv) ? vout_uv - step_uv
          : target_uv;
      end
    end
  end

endmodule

/* File: verilog/bkcv_regs.v */
// How it works
// - converter3_on low disables rail 3; high lets it run.
// - pin gating off or level mode: bit alone; else bit AND chosen enable pin.
// - gate_pin_choice_3 low picks enable pin a, high picks pin b.
// - level_pin_mode_3 high with pin gating on: pin high selects roof, low floor.
// - rail 3 off with discharge_on_3 high connects discharge; resets 1.
// - forced_switching_3 high forces PWM; low allows automatic PFM/PWM.
// - codes 0x00..0x17 decode as 0.5 V plus 10 mV per step.
// - codes 0x18..0x9D decode from 0.735 V in 5 mV steps.
// - codes 0x9E..0xFF decode from 1.42 V in 20 mV steps.
// - converter0_target_code resets to 0x39, i.e. 900 mV.
// - converter1_target_code resets to 0x75, i.e. 1200 mV.
// - floor state uses converter0_low_target_code; it resets 0x00.
// - limit code 0x2..0x7 gives 2.5 A to 5.0 A; changeable anytime.
// - ramp code sets rise and fall speed, 30 down to 0.4 mV/us.
`include "bkcv_defs.vh"

module bkcv_regs (
  // clock and reset
  input wire clk,
  input wire srst,
  // register port from the serial front end
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // hardware enable pins
  input wire hw_enable_in_a,
  input wire hw_enable_in_b,
  // rail 0 and 1 context from neighbouring logic
  input wire rail0_run,
  input wire rail0_floor_select,
  input wire [2:0] rail0_ramp_code,
  input wire rail1_run,
  input wire [2:0] rail1_ramp_code,
  // rail 3 controls
  output reg rail3_run,
  output reg rail3_discharge,
  output reg rail3_forced_pwm,
  output reg rail3_floor_select,
  output reg [12:0] rail3_ilim_ma,
  output reg [2:0] rail3_ramp_code,
  // rail 0 and 1 voltages in uV
  output wire [21:0] rail0_vout_uv,
  output wire rail0_settled,
  output wire [21:0] rail1_vout_uv,
  output wire rail1_settled
);

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  reg [7:0] rail3_control_q;
  reg [7:0] rail3_limits_ramp_q;
  reg [7:0] rail0_target_voltage_q;
  reg [7:0] rail0_floor_voltage_q;
  reg [7:0] rail1_target_voltage_q;

  // all bits, reserved ones too, are stored as written
  always @(posedge clk) begin
    if (srst) begin
      rail3_control_q <= `BKCV_RST_RAIL3_CONTROL;
      rail3_limits_ramp_q <= `BKCV_RST_RAIL3_LIMITS_RAMP;
      rail0_target_voltage_q <= `BKCV_RST_RAIL0_TARGET_VOLTAGE;
      rail0_floor_voltage_q <= `BKCV_RST_RAIL0_FLOOR_VOLTAGE;
      rail1_target_voltage_q <= `BKCV_RST_RAIL1_TARGET_VOLTAGE;
    end else if (reg_wr) begin
      case (reg_addr)
        `BKCV_OFS_RAIL3_CONTROL: rail3_control_q <= reg_wdata;
        `BKCV_OFS_RAIL3_LIMITS_RAMP:
          rail3_limits_ramp_q <= reg_wdata;
        `BKCV_OFS_RAIL0_TARGET_VOLTAGE: rail0_target_voltage_q <= reg_wdata;
        `BKCV_OFS_RAIL0_FLOOR_VOLTAGE: rail0_floor_voltage_q <= reg_wdata;
        `BKCV_OFS_RAIL1_TARGET_VOLTAGE: rail1_target_voltage_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  // read data holds until the next read; unmapped offsets read zero
  always @(posedge clk) begin
    if (srst) begin
      reg_rdata <= `BKCV_RD_UNMAPPED;
    end else if (reg_rd) begin
      case (reg_addr)
        `BKCV_OFS_RAIL3_CONTROL: reg_rdata <= rail3_control_q;
        `BKCV_OFS_RAIL3_LIMITS_RAMP: reg_rdata <= rail3_limits_ramp_q;
        `BKCV_OFS_RAIL0_TARGET_VOLTAGE: reg_rdata <= rail0_target_voltage_q;
        `BKCV_OFS_RAIL0_FLOOR_VOLTAGE: reg_rdata <= rail0_floor_voltage_q;
        `BKCV_OFS_RAIL1_TARGET_VOLTAGE: reg_rdata <= rail1_target_voltage_q;
        default: reg_rdata <= `BKCV_RD_UNMAPPED;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // enable pin synchronisers
  // ----------------------------------------------------------------
  // three stages; the filtered level moves only when stages two and
  // three agree, so a single-cycle glitch on a pin never gets through
  reg [1:0] pin_s1_q;
  reg [1:0] pin_s2_q;
  reg [1:0] pin_s3_q;
  reg [1:0] pin_q;

  always @(posedge clk) begin
    if (srst) begin
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
      pin_s3_q <= 2'h0;
      pin_q <= 2'h0;
    end else begin
      pin_s1_q <= {hw_enable_in_b, hw_enable_in_a};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      if (pin_s2_q[0] == pin_s3_q[0]) begin
        pin_q[0] <= pin_s3_q[0];
      end
      if (pin_s2_q[1] == pin_s3_q[1]) begin
        pin_q[1] <= pin_s3_q[1];
      end
    end
  end

  // ----------------------------------------------------------------
  // rail 3 control decode
  // ----------------------------------------------------------------
  wire conv3_on;
  wire gating3;
  wire choice3;
  wire level3;
  wire chosen_pin;
  wire run3_d;
  wire floor3_d;
  wire [2:0] ilim_code;
  wire [2:0] ilim_ofs;
  wire [12:0] ilim_ma_d;

  assign conv3_on = rail3_control_q[`BKCV_BIT_CONVERTER3_ON];
  assign gating3 = rail3_control_q[`BKCV_BIT_PIN_GATING_ON_3];
  assign choice3 = rail3_control_q[`BKCV_BIT_GATE_PIN_CHOICE_3];
  assign level3 = rail3_control_q[`BKCV_BIT_LEVEL_PIN_MODE_3];

  assign chosen_pin = choice3 ? pin_q[1] : pin_q[0];

  // in level mode the pin picks roof or floor and no longer gates the run
  assign run3_d = conv3_on
    && (!gating3 || level3 || chosen_pin);
  assign floor3_d = conv3_on && gating3 && level3 && !chosen_pin;

  // codes below 0x2 are undefined; they clamp to the lowest limit
  assign ilim_code = rail3_limits_ramp_q[`BKCV_ILIM_MSB:`BKCV_ILIM_LSB];
  assign ilim_ofs = (ilim_code < `BKCV_ILIM_CODE_MIN) ? 3'h0
    : ilim_code - `BKCV_ILIM_CODE_MIN;
  assign ilim_ma_d = `BKCV_ILIM_BASE_MA
    + {10'h000, ilim_ofs} * `BKCV_ILIM_STEP_MA;

  always @(posedge clk) begin
    if (srst) begin
      rail3_run <= 1'b0;
      rail3_discharge <= 1'b0;
      rail3_forced_pwm <= 1'b0;
      rail3_floor_select <= 1'b0;
      rail3_ilim_ma <= 13'h0000;
      rail3_ramp_code <= 3'h0;
    end else begin
      rail3_run <= run3_d;
      rail3_floor_select <= floor3_d;
      rail3_discharge <= !run3_d
        && rail3_control_q[`BKCV_BIT_DISCHARGE_ON_3];
      rail3_forced_pwm <=
        rail3_control_q[`BKCV_BIT_FORCED_SWITCHING_3];
      rail3_ilim_ma <= ilim_ma_d;
      rail3_ramp_code <=
        rail3_limits_ramp_q[`BKCV_RAMP_MSB:`BKCV_RAMP_LSB];
    end
  end

  // ----------------------------------------------------------------
  // microsecond tick for the ramps
  // ----------------------------------------------------------------
  localparam [5:0] TICK_LAST = `BKCV_RAMP_TICK_LAST;
  reg [5:0] tick_cnt_q;
  reg tick_q;

  always @(posedge clk) begin
    if (srst) begin
      tick_cnt_q <= 6'h00;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == TICK_LAST) begin
      tick_cnt_q <= 6'h00;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 6'h01;
      tick_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // rail 0 and rail 1 voltage ramps
  // ----------------------------------------------------------------
  wire [7:0] rail0_code;

  // switching roof and floor is itself a target change, so it slews too
  assign rail0_code = rail0_floor_select ? rail0_floor_voltage_q
    : rail0_target_voltage_q;

  bkcv_ramp u_ramp0 (
    .clk(clk),
    .srst(srst),
    .tick(tick_q),
    .run(rail0_run),
    .code(rail0_code),
    .speed(rail0_ramp_code),
    .vout_uv(rail0_vout_uv),
    .settled(rail0_settled)
  );

  bkcv_ramp u_ramp1 (
    .clk(clk),
    .srst(srst),
    .tick(tick_q),
    .run(rail1_run),
    .code(rail1_target_voltage_q),
    .speed(rail1_ramp_code),
    .vout_uv(rail1_vout_uv),
    .settled(rail1_settled)
  );

endmodule

/* File: verification/bkcv_regs_checker.sv */
`include "bkcv_defs.vh"

// ----------------------------------------
// rail 3 control and ramp checker
// ----------------------------------------
module bkcv_regs_checker (
  // clock and reset
  input wire clk,
  input wire srst,
  // register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  // rail 3 controls
  input wire rail3_run,
  input wire rail3_discharge,
  input wire rail3_forced_pwm,
  input wire rail3_floor_select,
  input wire [12:0] rail3_ilim_ma,
  input wire [2:0] rail3_ramp_code,
  // rails 0 and 1
  input wire rail0_run,
  input wire rail1_run,
  input wire [2:0] rail0_ramp_code,
  input wire [2:0] rail1_ramp_code,
  input wire [21:0] rail0_vout_uv,
  input wire [21:0] rail1_vout_uv,
  input wire rail0_settled,
  input wire rail1_settled
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [21:0] SLEW [8] = '{22'h00_7530, 22'h00_3A98,
    22'h00_2710, 22'h00_1D4C, 22'h00_0ED8, 22'h00_076C, 22'h00_03AC,
    22'h00_0190};
  function automatic logic [21:0] adiff(logic [21:0] a, logic [21:0] b);
    return (a > b) ? a - b : b - a;
  endfunction
  function automatic logic [12:0] ilim(logic [7:0] w);
    return (w[5:3] < 3'h2) ? 13'h09C4 : 13'h09C4 + (w[5:3] - 3'h2) * 13'h01F4;
  endfunction
  function automatic logic [2:0] lo3(logic [7:0] w);
    return w[2:0];
  endfunction
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  // a one-cycle lag of discharge behind run is tolerated
  AST_DISCHARGE: assert property (
    rail3_run && $past(rail3_run) |-> !rail3_discharge)
    else $error("discharge connected while rail 3 runs");
  // outputs still show reset zeros on the first edge after release
  AST_ILIM_RANGE: assert property (
    !$past(srst) |-> rail3_ilim_ma >= 13'h09C4 && rail3_ilim_ma <= 13'h1388
    && rail3_ilim_ma % 13'h01F4 == 13'h0000)
    else $error("current limit outside its steps");
  AST_ILIM_FOLLOW: assert property (
    reg_wr && reg_addr == 8'h09 |-> ##2 rail3_ilim_ma ==
    ilim($past(reg_wdata, 2)))
    else $error("current limit does not follow write");
  AST_RAMP_FOLLOW: assert property (
    reg_wr && reg_addr == 8'h09 |-> ##2 rail3_ramp_code ==
    lo3($past(reg_wdata, 2)))
    else $error("ramp code does not follow write");
  AST_PWM_SOURCE: assert property (
    $changed(rail3_forced_pwm) && !$past(srst) && !$past(srst, 2) |->
    $past(reg_wr, 2) && $past(reg_addr, 2) == 8'h08)
    else $error("forced pwm changed without control write");
  AST_SLEW0: assert property (
    rail0_run && $past(rail0_run) |-> adiff(rail0_vout_uv,
    $past(rail0_vout_uv)) <= SLEW[$past(rail0_ramp_code)])
    else $error("rail 0 moved faster than its ramp");
  AST_SLEW1: assert property (
    rail1_run && $past(rail1_run) |-> adiff(rail1_vout_uv,
    $past(rail1_vout_uv)) <= SLEW[$past(rail1_ramp_code)])
    else $error("rail 1 moved faster than its ramp");
  AST_FLOOR0_MIN: assert property (
    rail0_settled |-> rail0_vout_uv >= 22'h07_A120)
    else $error("rail 0 settled below lowest code");
  AST_RAIL1_SPAN: assert property (
    rail1_settled |-> rail1_vout_uv >= 22'h07_A120 &&
    rail1_vout_uv <= 22'h33_4500)
    else $error("rail 1 settled outside code span");
  cover property ($rose(rail3_run));
  cover property ($rose(rail3_floor_select));
  cover property ($rose(rail1_settled));
endmodule

bind bkcv_regs bkcv_regs_checker chk (.clk(clk), .srst(srst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .rail3_run(rail3_run), .rail3_discharge(rail3_discharge),
  .rail3_forced_pwm(rail3_forced_pwm),
  .rail3_floor_select(rail3_floor_select),
  .rail3_ilim_ma(rail3_ilim_ma), .rail3_ramp_code(rail3_ramp_code),
  .rail0_run(rail0_run), .rail1_run(rail1_run),
  .rail0_ramp_code(rail0_ramp_code), .rail1_ramp_code(rail1_ramp_code),
  .rail0_vout_uv(rail0_vout_uv), .rail1_vout_uv(rail1_vout_uv),
  .rail0_settled(rail0_settled), .rail1_settled(rail1_settled));

/* File: verification/bkcv_host.sv */
// ----------------------------------------
// host side of the register port
// ----------------------------------------
module bkcv_host (
  // clock
  input wire clk,
  // register port
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // callers keep reserved bits at zero
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule

/* File: verification/tb_top.sv */
// ----------------------------------------
// bench
// ----------------------------------------
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic hw_enable_in_a = 1'b0;
  logic hw_enable_in_b = 1'b0;
  logic rail0_run = 1'b0;
  logic rail0_floor_select = 1'b0;
  logic rail1_run = 1'b0;
  logic [2:0] rail0_ramp_code = 3'h0;
  logic [2:0] rail1_ramp_code = 3'h0;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire reg_wr, reg_rd, rail3_run, rail3_discharge, rail3_forced_pwm;
  wire rail3_floor_select, rail0_settled, rail1_settled;
  wire [12:0] rail3_ilim_ma;
  wire [2:0] rail3_ramp_code;
  wire [21:0] rail0_vout_uv, rail1_vout_uv;
  int error_cnt = 0;
  int n_compared = 0;
  logic [7:0] rd_q;
  always #12.5 clk = ~clk;

  bkcv_host host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  bkcv_regs dut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .hw_enable_in_a(hw_enable_in_a),
    .hw_enable_in_b(hw_enable_in_b), .rail0_run(rail0_run),
    .rail0_floor_select(rail0_floor_select),
    .rail0_ramp_code(rail0_ramp_code), .rail1_run(rail1_run),
    .rail1_ramp_code(rail1_ramp_code), .rail3_run(rail3_run),
    .rail3_discharge(rail3_discharge), .rail3_forced_pwm(rail3_forced_pwm),
    .rail3_floor_select(rail3_floor_select), .rail3_ilim_ma(rail3_ilim_ma),
    .rail3_ramp_code(rail3_ramp_code), .rail0_vout_uv(rail0_vout_uv),
    .rail0_settled(rail0_settled), .rail1_vout_uv(rail1_vout_uv),
    .rail1_settled(rail1_settled));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task w(input int n);
    repeat (n) @(negedge clk);
  endtask
  function automatic logic [21:0] vexp(logic [7:0] c);
    if (c <= 8'h17) return 22'h07_A120 + c * 22'h00_2710;
    if (c <= 8'h9D) return 22'h0B_3718 + (c - 8'h18) * 22'h00_1388;
    return 22'h15_AAE0 + (c - 8'h9E) * 22'h00_4E20;
  endfunction
  // bounded wait; the caller judges the count when speed matters
  task wfl(input bit sel, output int k);
    k = 0;
    while ((sel ? rail1_settled : rail0_settled) !== 1'b1 && k < 6000) begin
      @(negedge clk);
      k++;
    end
  endtask
  task end_of_test;
    $display("compared %0d, wrong %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task t_reset;
    logic [7:0] ofs [6];
    logic [7:0] val [6];
    ofs = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D};
    val = '{8'hCA, 8'h2A, 8'h39, 8'h00, 8'h75, 8'h00};
    for (int i = 0; i < 6; i++) begin
      host.rd(ofs[i], rd_q);
      chk(rd_q, val[i]);
    end
    chk(rail3_discharge, 1'b1);
    chk(rail3_forced_pwm, 1'b1);
    chk(rail3_ilim_ma, 13'h0FA0);
    chk(rail3_ramp_code, 3'h2);
    $display("t_reset done");
  endtask
  task t_ctrl;
    chk(rail3_run, 1'b0);
    hw_enable_in_a = 1'b1;
    w(8);
    chk(rail3_run, 1'b1);
    chk(rail3_discharge, 1'b0);
    host.wr(8'h08, 8'hEA);
    w(8);
    chk(rail3_run, 1'b0);
    hw_enable_in_b = 1'b1;
    w(8);
    chk(rail3_run, 1'b1);
    host.wr(8'h08, 8'h6A);
    w(3);
    chk(rail3_run, 1'b0);
    chk(rail3_discharge, 1'b1);
    host.wr(8'h08, 8'h62);
    w(3);
    chk(rail3_discharge, 1'b0);
    hw_enable_in_a = 1'b0;
    hw_enable_in_b = 1'b0;
    host.wr(8'h08, 8'h8A);
    w(8);
    chk(rail3_run, 1'b1);
    host.wr(8'h08, 8'hDA);
    w(8);
    chk(rail3_run, 1'b1);
    chk(rail3_floor_select, 1'b1);
    hw_enable_in_a = 1'b1;
    w(8);
    chk(rail3_floor_select, 1'b0);
    host.wr(8'h08, 8'hC8);
    w(3);
    chk(rail3_forced_pwm, 1'b0);
    host.wr(8'h08, 8'hCA);
    w(3);
    chk(rail3_forced_pwm, 1'b1);
    $display("t_ctrl done");
  endtask
  task t_lim;
    logic [12:0] ilim_exp;
    for (int i = 0; i < 8; i++) begin
      host.wr(8'h09, {2'b00, i[2:0], 3'h7 - i[2:0]});
      w(3);
      ilim_exp = (i < 2) ? 13'h09C4 : 13'h09C4 + (i - 2) * 13'h01F4;
      chk(rail3_ilim_ma, ilim_exp);
      chk(rail3_ramp_code, 3'h7 - i[2:0]);
      host.rd(8'h09, rd_q);
      chk(rd_q, {2'b00, i[2:0], 3'h7 - i[2:0]});
    end
    $display("t_lim done");
  endtask
  task t_rail1;
    logic [7:0] codes [6];
    logic [2:0] spd [6];
    int ticks [6];
    int k;
    codes = '{8'h00, 8'h17, 8'h18, 8'h9D, 8'h9E, 8'hFF};
    // ramp codes 1..6 once each; ticks is ceil(voltage step / rate)
    spd = '{3'h2, 3'h4, 3'h6, 3'h3, 3'h5, 3'h1};
    ticks = '{70, 61, 6, 89, 11, 130};
    rail1_run = 1'b1;
    wfl(1'b1, k);
    chk(rail1_vout_uv, vexp(8'h75));
    for (int i = 0; i < 6; i++) begin
      rail1_ramp_code = spd[i];
      host.wr(8'h0C, codes[i]);
      w(3);
      wfl(1'b1, k);
      chk(rail1_settled, 1'b1);
      chk(rail1_vout_uv, vexp(codes[i]));
      chk(k >= ticks[i] * 40 - 42 && k <= ticks[i] * 40 - 3, 1'b1);
    end
    $display("t_rail1 done");
  endtask
  task t_rail0;
    int k;
    rail0_run = 1'b1;
    wfl(1'b0, k);
    chk(rail0_vout_uv, vexp(8'h39));
    rail0_floor_select = 1'b1;
    w(3);
    wfl(1'b0, k);
    chk(rail0_vout_uv, vexp(8'h00));
    host.wr(8'h0B, 8'h18);
    w(3);
    wfl(1'b0, k);
    chk(rail0_vout_uv, vexp(8'h18));
    // slowest ramp: 10 mV takes 25 ticks of 40 cycles
    rail0_ramp_code = 3'h7;
    host.wr(8'h0B, 8'h1A);
    w(900);
    chk(rail0_settled, 1'b0);
    wfl(1'b0, k);
    chk(k < 200, 1'b1);
    chk(rail0_vout_uv, vexp(8'h1A));
    $display("t_rail0 done");
  endtask

  initial begin
    w(6);
    srst = 1'b0;
    w(3);
    t_reset;
    t_ctrl;
    t_lim;
    t_rail1;
    t_rail0;
    end_of_test;
  end
  initial begin
    #(25 * 40000);
    error_cnt++;
    end_of_test;
  end
endmodule
